/* core/tx_channel_inserter_insert.sv */
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ns
`include "tx_channel_inserter_regs.svh"

// Overview of operation
// R1 - three independent paths, each inserting its own hdlc transmitter's bits by its settings
// R2 - even select set inserts the link into even frames, clear leaves them alone
// R3 - odd select set inserts into odd frames; both set means every frame
// R4 - e1 frames count 0 to 15; t1 frames 1 to 12, or 1 to 24 esf
// R5 - 5-bit slot field picks the slot in binary; t1 channel n is value n-1
// R6 - slot field has no effect while both frame selects are clear
// R7 - only slot bits whose mask bit is one are replaced, others pass through
// R8 - mask bit 7 is the first bit sent, mask bit 0 the eighth
// R9 - software sets all eight mask bits to fill a whole slot
// R10 - mask has no effect while both frame selects of that link are clear
// R11 - link one framed enable in t1 follows framer bit locations; selects clear
// R12 - when links collide on one bit, the lowest-numbered link wins
module tx_channel_inserter_insert #(
  parameter int NUM_LINKS = 3
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  // register port
  input  wire logic [7:0]             reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [7:0]                  reg_rdata,
  // framing mode
  input  wire logic                   e1_mode,
  input  wire logic                   esf_mode,
  // transmit stream in
  input  wire logic                   tx_in_valid,
  input  wire logic                   tx_in_data,
  input  wire logic                   tx_frame_start,
  input  wire logic                   tx_mf_start,
  input  wire logic                   tx_fbit,
  input  wire logic                   tx_dl_loc,
  input  wire tx_channel_inserter_pkg::tx_channel_inserter_slot_t   tx_slot,
  input  wire tx_channel_inserter_pkg::tx_channel_inserter_bitpos_t tx_bitpos,
  // hdlc transmitters
  input  wire logic [NUM_LINKS-1:0]   hdlc_bit,
  output logic [NUM_LINKS-1:0]        hdlc_bit_req,
  // transmit stream out
  output logic                        tx_out_valid,
  output logic                        tx_out_data,
  output logic [NUM_LINKS-1:0]        tx_out_ins
);

  // --------------------------------------------------------------------------
  // register file
  // --------------------------------------------------------------------------
  tx_channel_inserter_pkg::tx_channel_inserter_byte_t ctrl_q [NUM_LINKS];
  tx_channel_inserter_pkg::tx_channel_inserter_byte_t mask_q [NUM_LINKS];
  logic [7:0]           rdata_q;
  logic [7:0]           rdata_d;

  wire logic [NUM_LINKS-1:0] hit_ctrl;
  wire logic [NUM_LINKS-1:0] hit_mask;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_LINKS; gi++) begin : g_reg
      localparam logic [7:0] CTRL_ADDR = 8'(`TX_CHANNEL_INSERTER_LINK1_CTRL_OFS + 2 * gi);
      localparam logic [7:0] MASK_ADDR = 8'(`TX_CHANNEL_INSERTER_LINK1_MASK_OFS + 2 * gi);
      localparam logic [7:0] CTRL_RST  = (gi == 0) ? `TX_CHANNEL_INSERTER_LINK1_CTRL_RST : `TX_CHANNEL_INSERTER_CTRL_RST;
      // only link one owns the framed enable; its bit reads zero elsewhere
      localparam logic [7:0] CTRL_WMSK = (gi == 0) ? 8'hff : 8'hdf;

      assign hit_ctrl[gi] = (reg_addr == CTRL_ADDR);
      assign hit_mask[gi] = (reg_addr == MASK_ADDR);

      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          ctrl_q[gi] <= CTRL_RST;
        end else if (reg_wr && hit_ctrl[gi]) begin
          ctrl_q[gi] <= reg_wdata & CTRL_WMSK;
        end
      end

      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          mask_q[gi] <= `TX_CHANNEL_INSERTER_MASK_RST;
        end else if (reg_wr && hit_mask[gi]) begin
          mask_q[gi] <= reg_wdata;
        end
      end
    end
  endgenerate

  // unmapped addresses read as zero
  always_comb begin
    rdata_d = 8'h00;
    for (int i = 0; i < NUM_LINKS; i++) begin
      if (hit_ctrl[i]) begin
        rdata_d = ctrl_q[i];
      end
      if (hit_mask[i]) begin
        rdata_d = mask_q[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = rdata_q;

  // --------------------------------------------------------------------------
  // frame numbering
  // --------------------------------------------------------------------------
  tx_channel_inserter_pkg::tx_channel_inserter_frame_t frame_q;
  tx_channel_inserter_pkg::tx_channel_inserter_frame_t frame_d;
  wire tx_channel_inserter_pkg::tx_channel_inserter_frame_t first_frame;
  wire tx_channel_inserter_pkg::tx_channel_inserter_frame_t last_frame;
  wire tx_channel_inserter_pkg::tx_channel_inserter_frame_t cur_frame;
  wire logic                  frame_odd;

  // t1 counts from one, e1 from zero, so parity differs per mode
  assign first_frame = e1_mode ? `TX_CHANNEL_INSERTER_E1_FIRST_FRAME : `TX_CHANNEL_INSERTER_T1_FIRST_FRAME; // R4
  assign last_frame  = e1_mode  ? `TX_CHANNEL_INSERTER_E1_LAST_FRAME :
                       esf_mode ? `TX_CHANNEL_INSERTER_ESF_LAST_FRAME : `TX_CHANNEL_INSERTER_SF_LAST_FRAME; // R4

  always_comb begin
    frame_d = frame_q;
    if (tx_in_valid && tx_frame_start) begin
      if (tx_mf_start || frame_q >= last_frame) begin
        frame_d = first_frame; // R4
      end else begin
        frame_d = frame_q + 5'h01; // R4
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      frame_q <= `TX_CHANNEL_INSERTER_E1_FIRST_FRAME;
    end else begin
      frame_q <= frame_d;
    end
  end

  // the first bit of a frame already belongs to the new number
  assign cur_frame = frame_d;
  assign frame_odd = cur_frame[0];

  // --------------------------------------------------------------------------
  // per-link selection
  // --------------------------------------------------------------------------
  wire logic [NUM_LINKS-1:0] want;
  wire logic [NUM_LINKS-1:0] grant;
  wire logic                 framed_link;

  // framed link one only counts in t1; software keeps its selects clear
  assign framed_link = ctrl_q[0][`TX_CHANNEL_INSERTER_FRAMED_EN_BIT] && !e1_mode; // R11

  generate
    for (gi = 0; gi < NUM_LINKS; gi++) begin : g_sel
      wire logic even_sel;
      wire logic odd_sel;
      wire logic frame_ok;
      wire logic slot_ok;
      wire logic mask_ok;
      wire logic framed_ok;

      assign even_sel = ctrl_q[gi][`TX_CHANNEL_INSERTER_EVEN_BIT];
      assign odd_sel  = ctrl_q[gi][`TX_CHANNEL_INSERTER_ODD_BIT];
      // with both selects clear, frame_ok is low, which masks slot and mask
      assign frame_ok = frame_odd ? odd_sel : even_sel; // R2 R3 R6 R10
      assign slot_ok  = (tx_slot == ctrl_q[gi][`TX_CHANNEL_INSERTER_SLOT_MSB:`TX_CHANNEL_INSERTER_SLOT_LSB]); // R5
      assign mask_ok  = mask_q[gi][3'd7 - tx_bitpos]; // R7 R8

      if (gi == 0) begin : g_framed
        assign framed_ok = framed_link && tx_dl_loc; // R11
      end else begin : g_plain
        assign framed_ok = 1'b0;
      end

      // the t1 framing bit is never a slot bit
      assign want[gi] = tx_in_valid &&
                        (framed_ok || (!tx_fbit && frame_ok && slot_ok && mask_ok)); // R1
    end
  endgenerate

  // lowest link wins; a losing transmitter keeps its bit for later
  assign grant = want & ~(want - NUM_LINKS'(1)) ; // R12

  // bit is pulled from the winning transmitter only
  assign hdlc_bit_req = grant; // R1

  // --------------------------------------------------------------------------
  // output stage
  // --------------------------------------------------------------------------
  logic                 out_valid_q;
  logic                 out_data_q;
  logic [NUM_LINKS-1:0] out_ins_q;
  wire logic            ins_bit;

  assign ins_bit = |(grant & hdlc_bit);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_valid_q <= 1'b0;
      out_data_q  <= 1'b0;
      out_ins_q   <= '0;
    end else begin
      out_valid_q <= tx_in_valid;
      out_data_q  <= (|grant) ? ins_bit : tx_in_data; // R7
      out_ins_q   <= grant;
    end
  end

  assign tx_out_valid = out_valid_q;
  assign tx_out_data  = out_data_q;
  assign tx_out_ins   = out_ins_q;

endmodule

/* core/tx_channel_inserter_pkg.sv */
package tx_channel_inserter_pkg;

  typedef logic [4:0] tx_channel_inserter_slot_t;
  typedef logic [4:0] tx_channel_inserter_frame_t;
  typedef logic [2:0] tx_channel_inserter_bitpos_t;
  typedef logic [7:0] tx_channel_inserter_byte_t;

endpackage

/* core/tx_channel_inserter_regs.svh */
`ifndef TX_CHANNEL_INSERTER_REGS_SVH
`define TX_CHANNEL_INSERTER_REGS_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define TX_CHANNEL_INSERTER_LINK1_CTRL_OFS  8'h38
`define TX_CHANNEL_INSERTER_LINK1_MASK_OFS  8'h39
`define TX_CHANNEL_INSERTER_LINK2_CTRL_OFS  8'h3a
`define TX_CHANNEL_INSERTER_LINK2_MASK_OFS  8'h3b
`define TX_CHANNEL_INSERTER_LINK3_CTRL_OFS  8'h3c
`define TX_CHANNEL_INSERTER_LINK3_MASK_OFS  8'h3d

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define TX_CHANNEL_INSERTER_EVEN_BIT        7
`define TX_CHANNEL_INSERTER_ODD_BIT         6
`define TX_CHANNEL_INSERTER_FRAMED_EN_BIT   5
`define TX_CHANNEL_INSERTER_SLOT_MSB        4
`define TX_CHANNEL_INSERTER_SLOT_LSB        0

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define TX_CHANNEL_INSERTER_LINK1_CTRL_RST  8'h20
`define TX_CHANNEL_INSERTER_CTRL_RST        8'h00
`define TX_CHANNEL_INSERTER_MASK_RST        8'h00

// ----------------------------------------------------------------------------
// frame numbering
// ----------------------------------------------------------------------------
`define TX_CHANNEL_INSERTER_E1_FIRST_FRAME  5'h00
`define TX_CHANNEL_INSERTER_E1_LAST_FRAME   5'h0f
`define TX_CHANNEL_INSERTER_T1_FIRST_FRAME  5'h01
`define TX_CHANNEL_INSERTER_SF_LAST_FRAME   5'h0c
`define TX_CHANNEL_INSERTER_ESF_LAST_FRAME  5'h18

`endif

/* test/tx_channel_inserter_hdlc_model.sv */
`timescale 1ns/1ns
module tx_channel_inserter_hdlc_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // link side
  input  wire logic [2:0] hdlc_bit_req,
  output logic      [2:0] hdlc_bit
);
  // distinct patterns per link so a swapped link shows up
  localparam logic [15:0] PAT [3] = '{16'h6b3c, 16'h9a55, 16'hc3a7};
  logic [3:0] pos_q [3];
  always_ff @(posedge clk or negedge rst_b) begin
    for (int i = 0; i < 3; i++) begin
      if (!rst_b) pos_q[i] <= 4'h0;
      else if (hdlc_bit_req[i]) pos_q[i] <= pos_q[i] + 4'h1;
    end
  end
  always_comb for (int i = 0; i < 3; i++) hdlc_bit[i] = PAT[i][pos_q[i]];
endmodule

/* test/tx_channel_inserter_insert_props.sv */
`timescale 1ns/1ns
module tx_channel_inserter_insert_props #(
  parameter int NUM_LINKS = 3
) (
  // clock, reset and register port
  input wire logic                   clk, rst_b, reg_wr, reg_rd,
  input wire logic [7:0]             reg_addr, reg_wdata, reg_rdata,
  // framer stream
  input wire logic                   e1_mode, esf_mode, tx_in_valid, tx_in_data,
  input wire logic                   tx_frame_start, tx_mf_start, tx_fbit, tx_dl_loc,
  input wire tx_channel_inserter_pkg::tx_channel_inserter_slot_t   tx_slot,
  input wire tx_channel_inserter_pkg::tx_channel_inserter_bitpos_t tx_bitpos,
  input wire logic                   tx_out_valid, tx_out_data,
  // links
  input wire logic [NUM_LINKS-1:0]   hdlc_bit, hdlc_bit_req, tx_out_ins
);
  // picked link bit, kept as a wire so $past sees a plain signal
  wire pick = |(hdlc_bit_req & hdlc_bit);
  wire any_req = |hdlc_bit_req;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_out_valid_lag: assert property (tx_in_valid |=> tx_out_valid)
    else $error("output valid missing after input bit");
  a_out_idle: assert property (!tx_in_valid |=> !tx_out_valid && tx_out_ins == 0)
    else $error("output active without input bit");
  a_req_qualified: assert property (any_req |-> tx_in_valid)
    else $error("link bit consumed without input bit");
  a_one_winner: assert property ($onehot0(hdlc_bit_req))
    else $error("more than one link consumed");
  a_ins_tracks_req: assert property (tx_in_valid |=> tx_out_ins == $past(hdlc_bit_req))
    else $error("insert flags differ from consumed link");
  a_data_mux: assert property (tx_in_valid |=> tx_out_data == ($past(any_req) ?
    $past(pick) : $past(tx_in_data))) else $error("output bit wrong source");
  a_fbit_kept: assert property (tx_in_valid && tx_fbit && !tx_dl_loc |-> !any_req)
    else $error("framing bit overwritten");
  a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data without read");
  a_unmapped_zero: assert property (reg_rd && (reg_addr < 8'h38 || reg_addr > 8'h3d)
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  c_link1: cover property (tx_in_valid && hdlc_bit_req[0]);
  c_link3: cover property (tx_in_valid && hdlc_bit_req[2]);
  c_read: cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule

bind tx_channel_inserter_insert tx_channel_inserter_insert_props #(.NUM_LINKS(NUM_LINKS)) tx_channel_inserter_insert_props_inst (
  .clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .e1_mode(e1_mode), .esf_mode(esf_mode),
  .tx_in_valid(tx_in_valid), .tx_in_data(tx_in_data), .tx_frame_start(tx_frame_start),
  .tx_mf_start(tx_mf_start), .tx_fbit(tx_fbit), .tx_dl_loc(tx_dl_loc), .tx_slot(tx_slot),
  .tx_bitpos(tx_bitpos), .tx_out_valid(tx_out_valid), .tx_out_data(tx_out_data),
  .hdlc_bit(hdlc_bit), .hdlc_bit_req(hdlc_bit_req), .tx_out_ins(tx_out_ins));

/* test/tx_channel_inserter_insert_test.sv */
`timescale 1ns/1ns
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module tx_channel_inserter_insert_test;
  logic clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, e1_mode = 1, esf_mode = 0;
  logic tx_in_valid = 0, tx_in_data = 1, fs = 0, mf = 0, fb = 0, dl = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  tx_channel_inserter_pkg::tx_channel_inserter_slot_t slot = 5'h00;
  tx_channel_inserter_pkg::tx_channel_inserter_bitpos_t bpos = 3'h0;
  logic [2:0] hdlc_bit, req, ins, hb;
  logic out_v, out_d;
  int failures = 0, cmp_count = 0, cyc = 0;
  initial forever #25 clk = ~clk;
  tx_channel_inserter_insert tx_channel_inserter_insert_inst (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .e1_mode(e1_mode), .esf_mode(esf_mode), .tx_in_valid(tx_in_valid), .tx_in_data(tx_in_data),
    .tx_frame_start(fs), .tx_mf_start(mf), .tx_fbit(fb), .tx_dl_loc(dl), .tx_slot(slot),
    .tx_bitpos(bpos), .hdlc_bit(hdlc_bit), .hdlc_bit_req(req), .tx_out_valid(out_v),
    .tx_out_data(out_d), .tx_out_ins(ins));
  tx_channel_inserter_hdlc_model tx_channel_inserter_hdlc_model_inst (.clk(clk), .rst_b(rst_b), .hdlc_bit_req(req),
    .hdlc_bit(hdlc_bit));
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 `CHK("reg_rdata", e, reg_rdata)
  endtask
  // x is the link expected to win the bit, 0 for pass-through
  task automatic snd(input logic [4:0] s, input logic [2:0] p, input logic f, m, input int x);
    logic [2:0] ev;
    ev = (x == 0) ? 3'b000 : 3'(1 << (x - 1));
    @(posedge clk);
    tx_in_valid <= 1'b1;
    slot <= s;
    bpos <= p;
    fs <= f;
    mf <= m;
    #1 hb = hdlc_bit;
    `CHK("hdlc_bit_req", ev, req)
    @(posedge clk);
    tx_in_valid <= 1'b0;
    #1 `CHK("tx_out_valid", 1'b1, out_v)
    `CHK("tx_out_ins", ev, ins)
    `CHK("tx_out_data", (x == 0) ? 1'b1 : hb[x - 1], out_d)
  endtask
  // frame start at slot 0 first, then probe slot 5 bits 0 and 1
  task automatic frames(input int first, last, n);
    int k;
    for (k = 0; k < n; k++) begin
      snd(5'h00, 3'h0, 1'b1, k == 0, 0);
      snd(5'h05, 3'h0, 1'b0, 1'b0, ((first + k % (last - first + 1)) % 2) ? 2 : 1);
      snd(5'h05, 3'h1, 1'b0, 1'b0, 3);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      wrap_up;
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 6; a++) rd(8'h38 + 8'(a), (a == 0) ? 8'h20 : 8'h00);
    wr(8'h3a, 8'hff);
    rd(8'h3a, 8'hdf);
    wr(8'h3e, 8'h5a);
    rd(8'h3e, 8'h00);
    wr(8'h38, 8'h85);
    wr(8'h39, 8'h80);
    wr(8'h3a, 8'h45);
    wr(8'h3b, 8'h80);
    wr(8'h3c, 8'hc5);
    wr(8'h3d, 8'hc0);
    frames(0, 15, 17);
    e1_mode <= 1'b0;
    frames(1, 12, 13);
    esf_mode <= 1'b1;
    frames(1, 24, 25);
    fb <= 1'b1;
    snd(5'h05, 3'h0, 1'b0, 1'b0, 0);
    fb <= 1'b0;
    wr(8'h38, 8'h05);
    wr(8'h3a, 8'h05);
    wr(8'h3c, 8'h05);
    snd(5'h05, 3'h0, 1'b0, 1'b0, 0);
    snd(5'h05, 3'h1, 1'b0, 1'b0, 0);
    wr(8'h3a, 8'hc7);
    wr(8'h3b, 8'hff);
    for (int p = 0; p < 8; p++) snd(5'h07, 3'(p), 1'b0, 1'b0, 2);
    wr(8'h3a, 8'h07);
    wr(8'h38, 8'h25);
    dl <= 1'b1;
    fb <= 1'b1;
    snd(5'h00, 3'h0, 1'b0, 1'b0, 1);
    wrap_up;
  end
endmodule
